// ==== src/angc_pkg.sv ====
// Constants, types and decode helper for the next-page receive and
// gigabit configuration register bank.
// Assumes a single management clock and a synchronous active-high reset.
`default_nettype none
package angc_pkg;

  localparam logic [4:0] ADDR_EXPANSION = 5'h06;
  localparam logic [4:0] ADDR_NP_RX = 5'h08;
  localparam logic [4:0] ADDR_GIG_CFG = 5'h09;
  localparam logic [4:0] ADDR_GIG_STS = 5'h0A;

  localparam logic [15:0] NP_RX_RESET = 16'h2001;
  localparam logic [15:0] GIG_CFG_RESET = 16'h0300;
  localparam logic [15:0] GIG_CFG_WMASK = 16'hFF80;
  localparam logic [15:0] EXP_FIXED = 16'h0064;
  localparam logic [15:0] ZERO16 = 16'h0000;

  localparam int EXP_PAGE_RX_BIT = 1;
  localparam int STS_MS_FAULT_BIT = 15;

  localparam int NP_REQ_BIT = 15;
  localparam int NP_ACK_BIT = 14;
  localparam int NP_MSG_BIT = 13;
  localparam int NP_COMPLY_ACKNOWLEDGE_BIT = 12;
  localparam int NP_TOG_BIT = 11;
  localparam int NP_CODE_MSB = 10;

  localparam int CFG_TEST_MSB = 15;
  localparam int CFG_TEST_LSB = 13;
  localparam int CFG_MS_EN_BIT = 12;
  localparam int CFG_MS_VAL_BIT = 11;
  localparam int CFG_PORT_BIT = 10;
  localparam int CFG_ADV_FD_BIT = 9;
  localparam int CFG_ADV_HD_BIT = 8;
  localparam int CFG_TDR_AUTO_BIT = 7;

  localparam logic [7:0] TEST_ONEHOT_NORMAL = 8'h01;

  typedef enum logic [2:0] {
    DIAG_LINK_WAIT = 3'h1,
    DIAG_LINK_UP = 3'h2,
    DIAG_LAUNCH = 3'h4
  } angc_diag_e;

  // Test-mode code to one-hot select, bit 0 is normal operation
  function automatic logic [7:0] angc_test_onehot(input logic [2:0] code);
    logic [7:0] sel;
    sel = TEST_ONEHOT_NORMAL << code;
    return sel;
  endfunction

endpackage : angc_pkg
`default_nettype wire

// ==== src/angc_page_capture.sv ====
// Capture of the link code word received from the link partner.
// Assumes pageValid is a one-cycle strobe from the arbitration logic.
`default_nettype none
module angc_page_capture
  import angc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic pageValid,
  input wire logic [15:0] pageWord,
  output logic [15:0] pageReg,
  output logic pageStrobe
);

  typedef struct packed {
    logic [15:0] page;
    logic strobe;
  } angc_cap_s;

  angc_cap_s cap_reg;
  angc_cap_s cap_next;

  always_comb begin
    cap_next = cap_reg;
    cap_next.strobe = 1'b0;
    if (pageValid) begin
      // Whole word at once so a reader never sees a mixed page
      cap_next.page = pageWord;
      cap_next.strobe = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cap_reg.page <= NP_RX_RESET;
      cap_reg.strobe <= 1'b0;
    end else begin
      cap_reg <= cap_next;
    end
  end

  assign pageReg = cap_reg.page;
  assign pageStrobe = cap_reg.strobe;

endmodule // angc_page_capture
`default_nettype wire

// ==== src/angc_top.sv ====
// Next-page receive register, gigabit configuration register and the
// two clear-on-read flags that belong with them.
// Assumes a single-cycle management read/write port in the clock domain,
// and status strobes from the auto-negotiation logic in the same domain.
`default_nettype none
module angc_top
  import angc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdData,
  output logic regRdValid,
  input wire logic pageValid,
  input wire logic [15:0] pageWord,
  input wire logic linkUp,
  input wire logic msConfigFault,
  output logic [7:0] testModeOneHot,
  output logic msManual,
  output logic msForceMaster,
  output logic portMulti,
  output logic advGigFull,
  output logic advGigHalf,
  output logic tdrStart
);

  typedef struct packed {
    logic [15:0] gigCfg;
    logic pageRxFlag;
    logic msFault;
    logic [15:0] rdData;
    logic rdValid;
    logic [7:0] testOneHot;
    angc_diag_e diag;
    logic tdrStart;
  } angc_state_s;

  angc_state_s state_reg;
  angc_state_s state_next;

  logic [15:0] npRxWord;
  logic pageStrobe;

  logic wrCfg;
  logic rdExp;
  logic rdSts;
  logic [15:0] cfgWritten;
  logic [15:0] expView;
  logic [15:0] stsView;

  angc_page_capture u_capture (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pageValid(pageValid),
    .pageWord(pageWord),
    .pageReg(npRxWord),
    .pageStrobe(pageStrobe)
  );

  assign wrCfg = regWrite && (regAddr == ADDR_GIG_CFG);
  assign rdExp = regRead && (regAddr == ADDR_EXPANSION);
  assign rdSts = regRead && (regAddr == ADDR_GIG_STS);

  // Reserved low bits never store, so they read back as zero
  assign cfgWritten = regWrData & GIG_CFG_WMASK;

  always_comb begin
    expView = EXP_FIXED;
    expView[EXP_PAGE_RX_BIT] = state_reg.pageRxFlag;
  end

  always_comb begin
    stsView = ZERO16;
    stsView[STS_MS_FAULT_BIT] = state_reg.msFault;
  end

  always_comb begin
    state_next = state_reg;
    state_next.rdValid = 1'b0;
    state_next.tdrStart = 1'b0;

    // Configuration write; the next-page receive word has no writable bit
    if (wrCfg) begin
      state_next.gigCfg = cfgWritten;
      state_next.testOneHot =
        angc_test_onehot(cfgWritten[CFG_TEST_MSB:CFG_TEST_LSB]);
    end

    // Read mux, data presented one cycle after the strobe
    if (regRead) begin
      state_next.rdValid = 1'b1;
      case (regAddr)
        ADDR_EXPANSION: begin
          state_next.rdData = expView;
        end
        ADDR_NP_RX: begin
          state_next.rdData = npRxWord;
        end
        ADDR_GIG_CFG: begin
          state_next.rdData = state_reg.gigCfg;
        end
        ADDR_GIG_STS: begin
          state_next.rdData = stsView;
        end
        default: begin
          state_next.rdData = ZERO16;
        end
      endcase
    end

    // Clear on read first, then a same-cycle event sets again
    if (rdExp) begin
      state_next.pageRxFlag = 1'b0;
    end
    if (pageStrobe) begin
      state_next.pageRxFlag = 1'b1;
    end

    if (rdSts) begin
      state_next.msFault = 1'b0;
    end
    if (msConfigFault) begin
      state_next.msFault = 1'b1;
    end

    // Automatic cable diagnostic on each loss of link
    case (state_reg.diag)
      DIAG_LINK_WAIT: begin
        if (linkUp) begin
          state_next.diag = DIAG_LINK_UP;
        end
      end
      DIAG_LINK_UP: begin
        if (!linkUp) begin
          if (state_reg.gigCfg[CFG_TDR_AUTO_BIT]) begin
            state_next.diag = DIAG_LAUNCH;
            state_next.tdrStart = 1'b1;
          end else begin
            state_next.diag = DIAG_LINK_WAIT;
          end
        end
      end
      DIAG_LAUNCH: begin
        // One launch per link-down event, then wait for link again
        state_next.diag = DIAG_LINK_WAIT;
      end
      default: begin
        state_next.diag = DIAG_LINK_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg.gigCfg <= GIG_CFG_RESET;
      state_reg.pageRxFlag <= 1'b0;
      state_reg.msFault <= 1'b0;
      state_reg.rdData <= ZERO16;
      state_reg.rdValid <= 1'b0;
      state_reg.testOneHot <= TEST_ONEHOT_NORMAL;
      state_reg.diag <= DIAG_LINK_WAIT;
      state_reg.tdrStart <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign regRdData = state_reg.rdData;
  assign regRdValid = state_reg.rdValid;
  assign testModeOneHot = state_reg.testOneHot;
  // Manual role only means anything while manual control is on
  assign msManual = state_reg.gigCfg[CFG_MS_EN_BIT];
  assign msForceMaster = state_reg.gigCfg[CFG_MS_VAL_BIT];
  assign portMulti = state_reg.gigCfg[CFG_PORT_BIT];
  assign advGigFull = state_reg.gigCfg[CFG_ADV_FD_BIT];
  assign advGigHalf = state_reg.gigCfg[CFG_ADV_HD_BIT];
  assign tdrStart = state_reg.tdrStart;

endmodule // angc_top
`default_nettype wire

// ==== tb/angc_properties.sv ====
// Port-level checks on the next-page receive and gigabit config bank.
// Assumes one clock, synchronous active-high reset; bound to angc_top.
`default_nettype none
module angc_properties
  import angc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regRdData,
  input wire logic regRdValid,
  input wire logic pageValid,
  input wire logic [15:0] pageWord,
  input wire logic msConfigFault,
  input wire logic [7:0] testModeOneHot,
  input wire logic msManual,
  input wire logic msForceMaster,
  input wire logic portMulti,
  input wire logic advGigFull,
  input wire logic advGigHalf,
  input wire logic tdrStart
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  wire cfgWr = regWrite && regAddr == ADDR_GIG_CFG;
  wire npRd = regRead && regAddr == ADDR_NP_RX;
  wire expRd = regRead && regAddr == ADDR_EXPANSION;
  wire stsRd = regRead && regAddr == ADDR_GIG_STS;
  // Write data one cycle back, so outputs can be tied to what was written
  logic [15:0] wd;
  always_ff @(posedge clk_sys) wd <= regWrData;
  sequence s_fault_rd;
    msConfigFault ##1 !stsRd ##1 stsRd;
  endsequence
  sequence s_sts_twice;
    (stsRd && !msConfigFault) ##1 !msConfigFault ##1 (stsRd && !msConfigFault);
  endsequence
  property p_page;
    logic [15:0] w;
    (pageValid, w = pageWord) ##1 !pageValid ##1 npRd |=> regRdData == w;
  endproperty
  a_test_mode: assert property (cfgWr |=> testModeOneHot == (8'h01 << wd[15:13]))
    else $error("test mode select wrong");
  a_ms_enable: assert property (cfgWr |=> msManual == wd[12])
    else $error("manual master/slave enable wrong");
  a_ms_value: assert property (cfgWr |=> msForceMaster == wd[11])
    else $error("master/slave value wrong");
  a_port_type: assert property (cfgWr |=> portMulti == wd[10])
    else $error("port type wrong");
  a_adv_abil: assert property (cfgWr |=> {advGigFull, advGigHalf} == wd[9:8])
    else $error("advertised abilities wrong");
  a_rsvd_zero: assert property (regRead && regAddr == ADDR_GIG_CFG |=> regRdData[6:0] == 7'h00)
    else $error("reserved config bits not zero");
  a_page_word: assert property (p_page)
    else $error("received word not stored whole");
  a_page_flag: assert property (pageValid ##2 expRd |=> regRdData[EXP_PAGE_RX_BIT])
    else $error("page flag not set");
  a_fault_latch: assert property (s_fault_rd |=> regRdData[STS_MS_FAULT_BIT])
    else $error("fault not latched");
  a_fault_clear: assert property (s_sts_twice |=> !regRdData[STS_MS_FAULT_BIT])
    else $error("fault not cleared by read");
  a_tdr_pulse: assert property (tdrStart |=> !tdrStart)
    else $error("diagnostic launch longer than a cycle");
endmodule // angc_properties
bind angc_top angc_properties u_props (.*);
`default_nettype wire

// ==== tb/angc_partner.sv ====
// Link partner model: sends next-page code words on request.
// Word lines are scrambled while idle so stale data is never mistaken.
`default_nettype none
module angc_partner
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic sendPage,
  input wire logic [15:0] pageBody,
  output logic pageValid,
  output logic [15:0] pageWord
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tog;
  initial begin
    pageValid = 1'h0;
    pageWord = 16'h0000;
    tog = 1'h0;
  end
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pageValid <= 1'h0;
      tog <= 1'h0;
    end else if (sendPage) begin
      pageValid <= 1'h1;
      pageWord <= {pageBody[15:12], tog, pageBody[10:0]};
      tog <= ~tog;
    end else begin
      pageValid <= 1'h0;
      pageWord <= ~pageWord;
    end
  end
endmodule // angc_partner
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for angc_top with a link partner model.
// One 20 MHz clock; registers reached through the strobe port.
`default_nettype none
module testbench
  import angc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'h0, sys_rst = 1'h1, regWrite = 1'h0, regRead = 1'h0, linkUp = 1'h0;
  logic msConfigFault = 1'h0, sendPage = 1'h0;
  logic [4:0] regAddr = 5'h00;
  logic [15:0] regWrData = 16'h0000, pageBody = 16'h0000, regRdData, pageWord;
  logic regRdValid, pageValid, msManual, msForceMaster, portMulti, advGigFull, advGigHalf, tdrStart;
  logic [7:0] testModeOneHot;
  int fail_count = 0, checked = 0, cyc = 0;
  angc_top dut (.*);
  angc_partner partner (.*);
  initial forever #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'h1;
    @(posedge clk_sys);
    regWrite <= 1'h0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e, input string n);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge clk_sys);
    regRead <= 1'h0;
    #1 chk(n, e, (regRdValid === 1'h1) ? regRdData : 16'hXXXX);
  endtask
  task automatic send(input logic [15:0] b);
    @(posedge clk_sys);
    sendPage <= 1'h1;
    pageBody <= b;
    @(posedge clk_sys);
    sendPage <= 1'h0;
    @(posedge clk_sys);
  endtask
  task automatic t_cfg;
    logic [15:0] d;
    for (int i = 0; i < 8; i++) begin
      d = {i[2:0], i[0], i[1], i[2], ~i[0], ~i[1], i[0], 7'h55};
      wr(ADDR_GIG_CFG, d);
      rd(ADDR_GIG_CFG, d & 16'hFF80, "cfg");
      chk("cfg outs", {8'h01 << i[2:0], 3'h0, d[12:8]}, {testModeOneHot, 3'h0, msManual, msForceMaster,
        portMulti, advGigFull, advGigHalf});
    end
  endtask
  task automatic t_page;
    // Partner overrides bit 11 with its toggle, so bodies carry it wrong
    send(16'hD8A5);
    rd(ADDR_NP_RX, 16'hD0A5, "np one");
    send(16'h275A);
    rd(ADDR_EXPANSION, EXP_FIXED | 16'h0002, "page flag");
    rd(ADDR_EXPANSION, EXP_FIXED, "flag cleared");
    wr(ADDR_NP_RX, 16'h0000);
    rd(ADDR_NP_RX, 16'h2F5A, "np two");
  endtask
  task automatic t_fault;
    @(posedge clk_sys);
    msConfigFault <= 1'h1;
    @(posedge clk_sys);
    msConfigFault <= 1'h0;
    rd(ADDR_GIG_STS, 16'h8000, "fault");
    rd(ADDR_GIG_STS, 16'h0000, "fault cleared");
  endtask
  task automatic t_tdr(input logic [15:0] c, input logic [15:0] n);
    logic [15:0] k;
    k = 16'h0000;
    wr(ADDR_GIG_CFG, c);
    linkUp <= 1'h1;
    repeat (3) @(posedge clk_sys);
    linkUp <= 1'h0;
    repeat (6) begin
      @(posedge clk_sys);
      #1 if (tdrStart === 1'h1) k++;
    end
    chk("tdr launches", n, k);
  endtask
  task automatic wrap_up;
    if (fail_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'h0;
    rd(ADDR_NP_RX, NP_RX_RESET, "np reset");
    rd(ADDR_GIG_CFG, GIG_CFG_RESET, "cfg reset");
    t_cfg();
    t_page();
    t_fault();
    t_tdr(16'h0380, 16'h0001);
    t_tdr(16'h0300, 16'h0000);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
